// ==== shared/imt_pkg.sv ====
/*
 package for the two-wire master transmitter: register offsets, reset values,
 status codes, field layouts and bit timing.
 assumes a 100 MHz system clock and a software register port of 8-bit data.
*/
package imt_pkg;

	localparam logic [1:0] ADDR_CTRL = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;
	localparam logic [1:0] ADDR_DATA = 2'h2;
	localparam logic [1:0] ADDR_MODE = 2'h3;

	typedef struct packed {
		logic flag;
		logic ack_en;
		logic start;
		logic stop;
		logic wc;
		logic en;
		logic rsvd;
		logic irq_en;
	} imt_ctrl_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} imt_pins_t;

	typedef enum logic [1:0] {
		MODE_MT,
		MODE_MR,
		MODE_ST,
		MODE_SR
	} imt_mode_t;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'hFF;
	localparam logic [1:0] PRESC_RESET = 2'h0;
	localparam imt_pins_t PINS_IDLE = 2'h3;
	localparam logic [7:0] STATUS_MASK = 8'hF8;

	localparam logic [7:0] CODE_IDLE = 8'hF8;
	localparam logic [7:0] CODE_START = 8'h08;
	localparam logic [7:0] CODE_REP_START = 8'h10;
	localparam logic [7:0] CODE_ADDR_ACK = 8'h18;
	localparam logic [7:0] CODE_ADDR_NACK = 8'h20;
	localparam logic [7:0] CODE_DATA_ACK = 8'h28;
	localparam logic [7:0] CODE_DATA_NACK = 8'h30;
	localparam logic [7:0] CODE_ARB_LOST = 8'h38;

	localparam logic [3:0] BYTE_BITS = 4'h8;

	localparam int CLK_PERIOD_NS = 10;
	localparam int BIT_TIME_NS = 10000;
	localparam logic [7:0] QTR_CYCLES = 8'(BIT_TIME_NS / (4 * CLK_PERIOD_NS));

endpackage

// ==== hdl/imt_sync.sv ====
/*
 two-stage synchroniser for the serial clock and data pins.
 assumes pin levels arrive from outside the clock domain.
*/
module imt_sync
	import imt_pkg::*;
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input imt_pkg::imt_pins_t pins_in,
	output imt_pkg::imt_pins_t pins_out
);
	imt_pins_t meta_q;
	imt_pins_t sync_q;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			meta_q <= PINS_IDLE;
			sync_q <= PINS_IDLE;
		end else begin
			meta_q <= pins_in;
			sync_q <= meta_q;
		end
	end

	assign pins_out = sync_q;

endmodule

// ==== hdl/imt_tick.sv ====
/*
 divider giving a one-cycle enable pulse every quarter bit period.
 assumes the system clock; counting holds at zero while disabled.
*/
module imt_tick
	import imt_pkg::*;
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic en_in,
	output logic tick_out
);
	logic [7:0] cnt_q;
	wire last_w = (cnt_q == QTR_CYCLES - 8'h01);

	always_ff @(posedge clk_in) begin
		if (!resetn_in || !en_in || last_w) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	assign tick_out = en_in && last_w;

endmodule

// ==== hdl/imt_master_tx.sv ====
/*
 two-wire master transmitter: control, status and data registers, bus watch,
 start, address, data, repeated start and stop sequencing.
 assumes open-drain pins resolved outside, a software port with one-cycle
 strobes, and read data returned in the following cycle.
*/
// Implementation choices: the placing of the registers and the address-and-strobe port.
module imt_master_tx
	import imt_pkg::*;
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [1:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_we_in,
	input wire logic reg_re_in,
	output logic [7:0] reg_rdata_out,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out
);
	import imt_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_START,
		ST_START2,
		ST_HOLD,
		ST_LOW,
		ST_HIGH,
		ST_RS_LOW,
		ST_RS_HIGH,
		ST_STOP_LOW,
		ST_STOP_HIGH,
		ST_STOP_END
	} imt_state_t;

	imt_state_t state_q;
	imt_ctrl_t ctrl_q;
	imt_mode_t mode_q;
	imt_pins_t pins_s;
	logic [7:0] data_q;
	logic [7:0] shift_q;
	logic [7:0] code_q;
	logic [7:0] rdata_q;
	logic [1:0] presc_q;
	logic [3:0] bitcnt_q;
	logic ph_q;
	logic sda_low_q;
	logic scl_low_q;
	logic own_q;
	logic addr_phase_q;
	logic flag_set_q;
	logic stop_done_q;
	logic sda_prev_q;
	logic busy_q;
	logic tick_w;

	// pin synchronisation and bit-rate enable
	imt_sync u_sync (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.pins_in({scl_in, sda_in}),
		.pins_out(pins_s)
	);

	imt_tick u_tick (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.en_in(ctrl_q.en),
		.tick_out(tick_w)
	);

	// register decode
	wire ctrl_we_w = reg_we_in && (reg_addr_in == ADDR_CTRL);
	wire status_we_w = reg_we_in && (reg_addr_in == ADDR_STATUS);
	wire data_we_w = reg_we_in && (reg_addr_in == ADDR_DATA);
	wire flag_clr_w = ctrl_we_w && reg_wdata_in[7];
	wire data_ok_w = data_we_w && ctrl_q.flag;
	wire data_coll_w = data_we_w && !ctrl_q.flag;
	wire [7:0] status_rd_w = {code_q[7:3], 1'b0, presc_q};
	wire [7:0] ctrl_rd_w = {ctrl_q[7:2], 1'b0, ctrl_q.irq_en};
	wire [7:0] rd_mux_w = (reg_addr_in == ADDR_CTRL) ? ctrl_rd_w :
		(reg_addr_in == ADDR_STATUS) ? status_rd_w :
		(reg_addr_in == ADDR_DATA) ? data_q : {6'h00, mode_q};

	// bus watch: start and stop seen on the wires
	wire start_det_w = pins_s.scl && sda_prev_q && !pins_s.sda;
	wire stop_det_w = pins_s.scl && !sda_prev_q && pins_s.sda;
	wire free_w = !busy_q && pins_s.scl && pins_s.sda;
	wire tx_bit_w = shift_q[7];
	wire last_bit_w = (bitcnt_q == BYTE_BITS);
	wire hold_go_w = (state_q == ST_HOLD) && !ctrl_q.flag && !flag_set_q;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			sda_prev_q <= 1'b1;
			busy_q <= 1'b0;
		end else begin
			sda_prev_q <= pins_s.sda;
			busy_q <= ctrl_q.en && (busy_q || start_det_w) && !stop_det_w;
		end
	end

	// control register: flag set wins over a clear in the same cycle
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			ctrl_q <= CTRL_RESET;
		end else begin
			if (ctrl_we_w) begin
				ctrl_q.ack_en <= reg_wdata_in[6];
				ctrl_q.start <= reg_wdata_in[5];
				ctrl_q.stop <= reg_wdata_in[4] && !stop_done_q;
				ctrl_q.en <= reg_wdata_in[2];
				ctrl_q.irq_en <= reg_wdata_in[0];
			end else if (stop_done_q) begin
				ctrl_q.stop <= 1'b0;
			end
			ctrl_q.flag <= flag_set_q || (ctrl_q.flag && !flag_clr_w);
			ctrl_q.wc <= data_coll_w || (ctrl_q.wc && !data_ok_w);
			ctrl_q.rsvd <= 1'b0;
		end
	end

	// data and prescaler registers, read port
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			data_q <= DATA_RESET;
			presc_q <= PRESC_RESET;
			rdata_q <= 8'h00;
		end else begin
			if (data_ok_w) begin
				data_q <= reg_wdata_in;
			end
			if (status_we_w) begin
				presc_q <= reg_wdata_in[1:0];
			end
			rdata_q <= reg_re_in ? rd_mux_w : 8'h00;
		end
	end

	// serial sequencer, advancing on quarter-bit ticks
	always_ff @(posedge clk_in) begin
		flag_set_q <= 1'b0;
		stop_done_q <= 1'b0;
		if (!resetn_in) begin
			state_q <= ST_IDLE;
			ph_q <= 1'b0;
			shift_q <= DATA_RESET;
			bitcnt_q <= 4'h0;
			sda_low_q <= 1'b0;
			scl_low_q <= 1'b0;
			own_q <= 1'b0;
			addr_phase_q <= 1'b0;
			mode_q <= MODE_MT;
			code_q <= CODE_IDLE;
		end else if (!ctrl_q.en) begin
			state_q <= ST_IDLE;
			ph_q <= 1'b0;
			sda_low_q <= 1'b0;
			scl_low_q <= 1'b0;
			own_q <= 1'b0;
		end else if (tick_w) begin
			unique case (state_q)
				ST_IDLE: begin
					if (ctrl_q.start && !ctrl_q.flag && free_w) begin
						sda_low_q <= 1'b1;
						state_q <= ST_START;
					end
				end
				ST_START: begin
					scl_low_q <= 1'b1;
					state_q <= ST_START2;
				end
				ST_START2: begin
					code_q <= own_q ? CODE_REP_START : CODE_START;
					own_q <= 1'b1;
					addr_phase_q <= 1'b1;
					flag_set_q <= 1'b1;
					state_q <= ST_HOLD;
				end
				ST_HOLD: begin
					if (hold_go_w) begin
						ph_q <= 1'b0;
						if (ctrl_q.stop) begin
							state_q <= ST_STOP_LOW;
						end else if (ctrl_q.start) begin
							state_q <= ST_RS_LOW;
						end else begin
							shift_q <= data_q;
							bitcnt_q <= 4'h0;
							state_q <= ST_LOW;
							if (addr_phase_q) begin
								mode_q <= data_q[0] ? MODE_MR : MODE_MT;
							end
						end
					end
				end
				ST_LOW: begin
					if (!ph_q) begin
						sda_low_q <= !last_bit_w && !tx_bit_w;
						ph_q <= 1'b1;
					end else begin
						scl_low_q <= 1'b0;
						ph_q <= 1'b0;
						state_q <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					if (pins_s.scl && !ph_q) begin
						ph_q <= 1'b1;
					end else if (pins_s.scl) begin
						ph_q <= 1'b0;
						if (!last_bit_w && tx_bit_w && !pins_s.sda) begin
							sda_low_q <= 1'b0;
							own_q <= 1'b0;
							addr_phase_q <= 1'b0;
							code_q <= CODE_ARB_LOST;
							flag_set_q <= 1'b1;
							state_q <= ST_IDLE;
						end else if (!last_bit_w) begin
							scl_low_q <= 1'b1;
							shift_q <= {shift_q[6:0], 1'b0};
							bitcnt_q <= bitcnt_q + 4'h1;
							state_q <= ST_LOW;
						end else begin
							scl_low_q <= 1'b1;
							addr_phase_q <= 1'b0;
							flag_set_q <= 1'b1;
							state_q <= ST_HOLD;
							if (addr_phase_q) begin
								code_q <= pins_s.sda ? CODE_ADDR_NACK : CODE_ADDR_ACK;
							end else begin
								code_q <= pins_s.sda ? CODE_DATA_NACK : CODE_DATA_ACK;
							end
						end
					end
				end
				ST_RS_LOW: begin
					if (!ph_q) begin
						sda_low_q <= 1'b0;
						ph_q <= 1'b1;
					end else begin
						scl_low_q <= 1'b0;
						ph_q <= 1'b0;
						state_q <= ST_RS_HIGH;
					end
				end
				ST_RS_HIGH: begin
					if (pins_s.scl) begin
						sda_low_q <= 1'b1;
						state_q <= ST_START;
					end
				end
				ST_STOP_LOW: begin
					if (!ph_q) begin
						sda_low_q <= 1'b1;
						ph_q <= 1'b1;
					end else begin
						scl_low_q <= 1'b0;
						ph_q <= 1'b0;
						state_q <= ST_STOP_HIGH;
					end
				end
				ST_STOP_HIGH: begin
					if (pins_s.scl) begin
						sda_low_q <= 1'b0;
						state_q <= ST_STOP_END;
					end
				end
				ST_STOP_END: begin
					stop_done_q <= 1'b1;
					own_q <= 1'b0;
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// open-drain pins: drive low only
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_out = scl_low_q;
	assign sda_oe_out = sda_low_q;
	assign reg_rdata_out = rdata_q;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);

	a_hold_stays_put: assert property (
		(state_q == ST_HOLD && ctrl_q.flag && ctrl_q.en) |=> (state_q == ST_HOLD && scl_low_q))
		else $error("transfer moved while step flag set");

	a_start_only_free: assert property (
		(state_q == ST_IDLE && tick_w && ctrl_q.en && !free_w) |=> (state_q == ST_IDLE))
		else $error("start driven on a busy bus");

	a_start_code_set: assert property (
		(state_q == ST_START2 && tick_w && ctrl_q.en && !own_q) |=> ##1
		(ctrl_q.flag && code_q == CODE_START))
		else $error("start status not reported");

	a_addr_code_set: assert property (
		(state_q == ST_HIGH && tick_w && ph_q && pins_s.scl && last_bit_w && addr_phase_q
		&& ctrl_q.en) |=> ##1 (ctrl_q.flag && (code_q == CODE_ADDR_ACK
		|| code_q == CODE_ADDR_NACK)))
		else $error("address status not reported");

	a_collision_drop: assert property (
		(data_we_w && !ctrl_q.flag) |=> (ctrl_q.wc && data_q == $past(data_q)))
		else $error("collided data write not dropped");

	a_flag_zero_write: assert property (
		(ctrl_we_w && !reg_wdata_in[7] && ctrl_q.flag) |=> ctrl_q.flag)
		else $error("step flag cleared by writing zero");

	a_disable_release: assert property (
		(!ctrl_q.en) |=> (state_q == ST_IDLE && !scl_low_q && !sda_low_q))
		else $error("bus driven while disabled");

	a_byte_restart: assert property (
		(hold_go_w && !ctrl_q.stop && !ctrl_q.start && tick_w && ctrl_q.en) |=>
		(state_q == ST_LOW && bitcnt_q == 4'h0 && shift_q == $past(data_q)))
		else $error("next byte not loaded");

	a_ack_released: assert property (
		(state_q == ST_HIGH && last_bit_w) |-> !sda_low_q)
		else $error("sda held during acknowledge");

	a_data_ack_code: assert property (
		(state_q == ST_HIGH && tick_w && ph_q && pins_s.scl && last_bit_w && !addr_phase_q
		&& !pins_s.sda && ctrl_q.en) |=> ##1 (ctrl_q.flag && code_q == CODE_DATA_ACK))
		else $error("data ack status wrong");

	a_data_nack_code: assert property (
		(state_q == ST_HIGH && tick_w && ph_q && pins_s.scl && last_bit_w && !addr_phase_q
		&& pins_s.sda && ctrl_q.en) |=> ##1 (ctrl_q.flag && code_q == CODE_DATA_NACK))
		else $error("data nack status wrong");

	a_stop_self_clear: assert property (
		(state_q == ST_STOP_END && tick_w && ctrl_q.en && !reg_we_in) ##1 !reg_we_in
		|=> !ctrl_q.stop)
		else $error("stop request not cleared");

	a_byte_needs_start: assert property (
		(state_q == ST_LOW || state_q == ST_HIGH) |-> own_q)
		else $error("byte sent without start");

endmodule

// ==== sim/imt_slave_model.sv ====
/*
 behavioural slave receiver on the two-wire bus: takes bytes, answers ack or nack,
 may stretch the clock low after each falling edge.
 assumes resolved wire levels with pull-ups; it drives only open-drain enables.
*/
module imt_slave_model (
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic nack_in,
	input wire logic stretch_in,
	output logic scl_oe_out,
	output logic sda_oe_out,
	output logic [7:0] byte_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sh_q;
	int cnt_q;
	logic on_q;
	logic ack_q;
	initial begin
		scl_oe_out = 1'b0;
		sda_oe_out = 1'b0;
		byte_out = 8'h00;
		sh_q = 8'h00;
		cnt_q = 0;
		on_q = 1'b0;
		ack_q = 1'b0;
	end
	// start condition
	always @(negedge sda_in) if (scl_in) begin
		on_q = 1'b1;
		cnt_q = 0;
		ack_q = 1'b0;
	end
	// stop condition
	always @(posedge sda_in) if (scl_in) on_q = 1'b0;
	// msb first, eight bits a byte
	always @(posedge scl_in) if (on_q && cnt_q < 8) begin
		sh_q = {sh_q[6:0], sda_in};
		cnt_q++;
	end
	// data changes only while the clock is low
	always @(negedge scl_in) if (on_q) begin
		if (ack_q) begin
			sda_oe_out = 1'b0;
			ack_q = 1'b0;
			cnt_q = 0;
			byte_out = sh_q;
		end else if (cnt_q == 8) begin
			sda_oe_out = ~nack_in;
			ack_q = 1'b1;
		end
		if (stretch_in) begin
			scl_oe_out = 1'b1;
			#9000 scl_oe_out = 1'b0;
		end
	end
endmodule

// ==== sim/imt_master_tx_tb_top.sv ====
/*
 testbench for the two-wire master transmitter: registers, transfers, repeated start,
 stop, suspension, write collision and disable.
 assumes the slave model on the wires and the package timing of 250 clocks a quarter bit.
*/
module imt_master_tx_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import imt_pkg::*;
	logic clk;
	logic resetn;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic we;
	logic re;
	logic [7:0] rdata;
	logic scl_oe;
	logic sda_oe;
	logic s_scl_oe;
	logic s_sda_oe;
	logic nack;
	logic stretch;
	logic [7:0] rx;
	logic [7:0] v;
	logic scl_w;
	logic sda_w;
	int fail_count;
	int n_checks;
	assign scl_w = ~(scl_oe | s_scl_oe);
	assign sda_w = ~(sda_oe | s_sda_oe);
	imt_master_tx u_imt_master_tx (.clk_in(clk), .resetn_in(resetn), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_we_in(we), .reg_re_in(re), .reg_rdata_out(rdata),
		.scl_in(scl_w), .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(),
		.sda_oe_out(sda_oe));
	imt_slave_model u_imt_slave_model (.scl_in(scl_w), .sda_in(sda_w), .nack_in(nack),
		.stretch_in(stretch), .scl_oe_out(s_scl_oe), .sda_oe_out(s_sda_oe), .byte_out(rx));
	task automatic test_done();
		$display("checks=%0d errors=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 d = rdata;
	endtask
	// poll the step flag, then compare the masked status code
	task automatic step(input logic [7:0] code);
		int i;
		for (i = 0; i < 8000; i++) begin
			rd(ADDR_CTRL, v);
			if (v[7]) break;
		end
		chk(v & 8'h80, 8'h80);
		rd(ADDR_STATUS, v);
		chk(v & STATUS_MASK, code);
	endtask
	task automatic send(input logic [7:0] d, input logic [7:0] code);
		wr(ADDR_DATA, d);
		wr(ADDR_CTRL, 8'h84);
		step(code);
	endtask
	task automatic stop_done();
		int i;
		wr(ADDR_CTRL, 8'h94);
		for (i = 0; i < 3000; i++) begin
			rd(ADDR_CTRL, v);
			if (!v[4]) break;
		end
		chk(v & 8'h10, 8'h00);
		repeat (20) @(posedge clk);
		chk({6'h00, scl_w, sda_w}, 8'h03);
	endtask
	task automatic t_regs();
		rd(ADDR_CTRL, v);
		chk(v, CTRL_RESET);
		rd(ADDR_STATUS, v);
		chk(v, CODE_IDLE);
		rd(ADDR_DATA, v);
		chk(v, DATA_RESET);
		wr(ADDR_STATUS, 8'h03);
		rd(ADDR_STATUS, v);
		chk(v, 8'hFB);
		wr(ADDR_STATUS, 8'h00);
		wr(ADDR_CTRL, 8'h02);
		rd(ADDR_CTRL, v);
		chk(v, 8'h00);
		wr(ADDR_DATA, 8'h33);
		rd(ADDR_DATA, v);
		chk(v, DATA_RESET);
		rd(ADDR_CTRL, v);
		chk(v, 8'h08);
		wr(ADDR_MODE, 8'hFF);
		rd(ADDR_MODE, v);
		chk(v, 8'h00);
	endtask
	task automatic t_write();
		wr(ADDR_CTRL, 8'hA4);
		step(CODE_START);
		wr(ADDR_DATA, 8'hA0);
		rd(ADDR_CTRL, v);
		chk(v & 8'h08, 8'h00);
		wr(ADDR_CTRL, 8'h84);
		step(CODE_ADDR_ACK);
		chk(rx, 8'hA0);
		rd(ADDR_MODE, v);
		chk(v, 8'h00);
		wr(ADDR_CTRL, 8'h04);
		repeat (600) @(posedge clk);
		rd(ADDR_CTRL, v);
		chk(v & 8'h80, 8'h80);
		chk({7'h00, scl_oe}, 8'h01);
		rd(ADDR_STATUS, v);
		chk(v & STATUS_MASK, CODE_ADDR_ACK);
		stretch <= 1'b1;
		send(8'h5A, CODE_DATA_ACK);
		stretch <= 1'b0;
		chk(rx, 8'h5A);
		nack <= 1'b1;
		send(8'hC3, CODE_DATA_NACK);
		nack <= 1'b0;
		chk(rx, 8'hC3);
		stop_done();
	endtask
	task automatic t_restart();
		wr(ADDR_CTRL, 8'hA4);
		step(CODE_START);
		nack <= 1'b1;
		send(8'h52, CODE_ADDR_NACK);
		nack <= 1'b0;
		wr(ADDR_CTRL, 8'hA4);
		step(CODE_REP_START);
		send(8'h53, CODE_ADDR_ACK);
		rd(ADDR_MODE, v);
		chk(v, 8'h01);
		stop_done();
	endtask
	task automatic t_disable();
		wr(ADDR_CTRL, 8'hA4);
		step(CODE_START);
		wr(ADDR_CTRL, 8'h00);
		repeat (2) @(posedge clk);
		chk({6'h00, scl_oe, sda_oe}, 8'h00);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#900_000;
		fail_count++;
		test_done();
	end
	initial begin
		resetn = 1'b0;
		addr = 2'h0;
		wdata = 8'h00;
		we = 1'b0;
		re = 1'b0;
		nack = 1'b0;
		stretch = 1'b0;
		fail_count = 0;
		n_checks = 0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		t_regs();
		t_write();
		t_restart();
		t_disable();
		test_done();
	end
endmodule
